// ---- hdl/rtop_regs.vh ----
// Purpose: Constants for the timed output port block.
// Assumes: 10 MHz clock, byte-wide register port.
// Notes: Register offsets are local choices.
// Function
// RULE1: Ports 0, 4, 5, 6, 8 and 9 set each pin as input or output, with pull-up on inputs.
// RULE2: Port 7 is input only and has no pull-up.
// RULE3: A channel is a buffer register plus the output latch, copied on its trigger.
// RULE4: The port-0 channel runs as two 4-bit nibbles or one 8-bit channel, assigned per nibble.
// RULE5: The port-8 channel has a 1-bit and a 2-bit channel assigned per bit (0, 2, 3); here bits 2 and 3 are assigned together by hs_en.
// RULE6: The port-0 upper nibble loads on timer 0 match b.
// RULE7: The port-0 lower nibble and 8-bit mode load on timer 0 match c or the other source.
// RULE8: Port-8 bit 0 uses one of four software-selected triggers.
// RULE9: In port-8 timed mode, bits 2 and 3 show the head switch control levels.
// RULE10: Head switch levels normally update on timer 0 match a.
// RULE11: A write to the head switch control register drives the pins at once.
// RULE12: The pseudo vsync bit can drive low, high or high impedance.
// RULE13: The pseudo vsync bit can superimpose a horizontal sync signal.
// RULE14: In pseudo vsync mode each trigger makes the bit emit a fixed pattern repeatedly.
// RULE15: Buffer writes reach pins only on trigger; unassigned pins act as plain port bits.
// RULE16: The pseudo vsync pattern and hsync timing are configurable parameters; here only the pattern and the PV_STEP_CYC step time are.
`ifndef RTOP_REGS_VH
`define RTOP_REGS_VH
`define RTOP_ADDR_W 5
`define RTOP_P0_LATCH 5'h00
`define RTOP_P0_DIR 5'h01
`define RTOP_P4_LATCH 5'h02
`define RTOP_P4_DIR 5'h03
`define RTOP_P5_LATCH 5'h04
`define RTOP_P5_DIR 5'h05
`define RTOP_P6_LATCH 5'h06
`define RTOP_P6_DIR 5'h07
`define RTOP_P7_PINS 5'h08
`define RTOP_P8_LATCH 5'h09
`define RTOP_P8_DIR 5'h0a
`define RTOP_P9_LATCH 5'h0b
`define RTOP_P9_DIR 5'h0c
`define RTOP_P0_BUF 5'h0d
`define RTOP_P0_MODE 5'h0e
`define RTOP_P8_BUF 5'h0f
`define RTOP_P8_MODE 5'h10
`define RTOP_HSW_CTRL 5'h11
`define RTOP_PV_PAT 5'h12
`define RTOP_P0_IN 5'h13
`define RTOP_P4_IN 5'h14
`define RTOP_P5_IN 5'h15
`define RTOP_P6_IN 5'h16
`define RTOP_P8_IN 5'h17
`define RTOP_P9_IN 5'h18
// Port-0 mode fields
`define RTOP_P0M_LO_EN 0
`define RTOP_P0M_HI_EN 1
`define RTOP_P0M_WIDE 2
`define RTOP_P0M_ALT 3
// Port-8 mode fields
`define RTOP_P8M_B0_EN 0
`define RTOP_P8M_HS_EN 1
`define RTOP_P8M_SEL_LO 2
`define RTOP_P8M_SEL_HI 3
`define RTOP_P8M_HSYNC 4
`define RTOP_P8M_PVMODE 5
// Port-8 buffer fields: bit 0 level, bit 1 high impedance
`define RTOP_P8B_LVL 0
`define RTOP_P8B_HIZ 1
// Head switch control fields
`define RTOP_HSW_HEAD 0
`define RTOP_HSW_CHROMA 1
// Trigger select codes
`define RTOP_SEL_T0B 2'h0
`define RTOP_SEL_T0C 2'h1
`define RTOP_SEL_T1D 2'h2
`define RTOP_SEL_T5 2'h3
// Reset values
`define RTOP_RST_BYTE 8'h00
`define RTOP_RST_DIR 8'hff
`define RTOP_RST_PAT 8'h5a
// Pseudo vsync step time in ns and cycles at 100 ns
`define RTOP_PV_STEP_NS 32000
`define RTOP_CLK_NS 100
`define RTOP_PV_STEP_CYC 16'h0140
`define RTOP_PV_REPEAT 4'h3
`endif

// ---- hdl/rtop_pin_port.v ----
// Purpose: One 8-bit bidirectional port with pull-up on inputs.
// Assumes: Latch and direction come from the same clock.
// Notes: Direction bit 1 means input, pin enable low drives.
`timescale 1ns/1ns
module rtop_pin_port (
    input wire clk_in,
    input wire rst_in,
    input wire [7:0] latch_in,
    input wire [7:0] dir_in,
    input wire [7:0] pin_in,
    output reg [7:0] pin_out,
    output reg [7:0] pin_oe_n_out,
    output reg [7:0] pullup_out,
    output reg [7:0] sync_out
);
    reg [7:0] meta;
    always @(posedge clk_in) begin
        if (rst_in) begin
            pin_out <= 8'h00;
            pin_oe_n_out <= 8'hff;
            pullup_out <= 8'h00;
            meta <= 8'h00;
            sync_out <= 8'h00;
        end else begin
            pin_out <= latch_in;
            // RULE1: per-bit direction
            pin_oe_n_out <= dir_in;
            // RULE1: pull-up on inputs
            pullup_out <= dir_in;
            meta <= pin_in;
            sync_out <= meta;
        end
    end
endmodule

// ---- hdl/rtop_timed_port.v ----
// Purpose: Timed output port logic with ordinary general ports.
// Assumes: Triggers are one-cycle pulses from same-clock timers.
// Notes: Port-8 bit 1 does not exist and reads as zero.
//
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/1ns
`include "rtop_regs.vh"
module rtop_timed_port #(
    parameter [7:0] PV_PATTERN = `RTOP_RST_PAT,
    parameter [15:0] PV_STEP_CYC = `RTOP_PV_STEP_CYC
) (
    input wire clk_in,
    input wire rst_in,
    input wire [4:0] addr_in,
    input wire [7:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    output reg [7:0] rdata_out,
    input wire timer0_match_a_in,
    input wire timer0_match_b_in,
    input wire timer0_match_c_in,
    input wire timer1_match_d_in,
    input wire timer5_match_in,
    input wire alt_trigger_in,
    input wire hsync_in,
    input wire [7:0] p0_pin_in,
    output wire [7:0] p0_pin_out,
    output wire [7:0] p0_oe_n_out,
    output wire [7:0] p0_pullup_out,
    input wire [7:0] p4_pin_in,
    output wire [7:0] p4_pin_out,
    output wire [7:0] p4_oe_n_out,
    output wire [7:0] p4_pullup_out,
    input wire [7:0] p5_pin_in,
    output wire [7:0] p5_pin_out,
    output wire [7:0] p5_oe_n_out,
    output wire [7:0] p5_pullup_out,
    input wire [7:0] p6_pin_in,
    output wire [7:0] p6_pin_out,
    output wire [7:0] p6_oe_n_out,
    output wire [7:0] p6_pullup_out,
    input wire [7:0] p7_pin_in,
    input wire [7:0] p8_pin_in,
    output reg [7:0] p8_pin_out,
    output reg [7:0] p8_oe_n_out,
    output reg [7:0] p8_pullup_out,
    input wire [7:0] p9_pin_in,
    output wire [7:0] p9_pin_out,
    output wire [7:0] p9_oe_n_out,
    output wire [7:0] p9_pullup_out
);
    reg [7:0] p0_latch;
    reg [7:0] p0_dir;
    reg [7:0] p4_latch;
    reg [7:0] p4_dir;
    reg [7:0] p5_latch;
    reg [7:0] p5_dir;
    reg [7:0] p6_latch;
    reg [7:0] p6_dir;
    reg [7:0] p8_latch;
    reg [7:0] p8_dir;
    reg [7:0] p9_latch;
    reg [7:0] p9_dir;
    reg [7:0] p0_buf;
    reg [3:0] p0_mode;
    reg [1:0] p8_buf;
    reg [5:0] port8_mode_ctrl;
    reg [1:0] head_switch_ctrl_reg;
    reg [1:0] hsw_out;
    reg [1:0] pv_out;
    reg [7:0] pv_pat;
    reg pv_run;
    reg [2:0] pv_idx;
    reg [3:0] pv_rep;
    reg [15:0] pv_cnt;
    reg [7:0] p7_meta;
    reg [7:0] p7_sync;
    reg [7:0] p8_meta;
    reg [7:0] p8_sync;
    wire [7:0] p0_sync;
    wire [7:0] p4_sync;
    wire [7:0] p5_sync;
    wire [7:0] p6_sync;
    wire [7:0] p9_sync;
    wire [7:0] p0_eff_dir;
    reg [7:0] p0_eff_latch;
    wire lo_trig;
    wire hi_trig;
    reg b0_trig;
    wire b0_en;
    wire hs_en;
    reg pv_level;
    reg pv_hiz;

    // RULE7: lower and wide trigger
    assign lo_trig = p0_mode[`RTOP_P0M_ALT] ? alt_trigger_in :
        timer0_match_c_in;
    // RULE6: upper nibble trigger
    assign hi_trig = p0_mode[`RTOP_P0M_WIDE] ? lo_trig : timer0_match_b_in;
    assign b0_en = port8_mode_ctrl[`RTOP_P8M_B0_EN];
    assign hs_en = port8_mode_ctrl[`RTOP_P8M_HS_EN];

    // RULE8: one of four sources
    always @* begin
        case (port8_mode_ctrl[`RTOP_P8M_SEL_HI:`RTOP_P8M_SEL_LO])
            `RTOP_SEL_T0B: b0_trig = timer0_match_b_in;
            `RTOP_SEL_T0C: b0_trig = timer0_match_c_in;
            `RTOP_SEL_T1D: b0_trig = timer1_match_d_in;
            default: b0_trig = timer5_match_in;
        endcase
    end

    // RULE4: nibble-wise pin assignment
    assign p0_eff_dir = {
        p0_mode[`RTOP_P0M_HI_EN] ? 4'h0 : p0_dir[7:4],
        p0_mode[`RTOP_P0M_LO_EN] ? 4'h0 : p0_dir[3:0]};

    always @* begin
        p0_eff_latch = p0_latch;
    end

    rtop_pin_port u_p0 (.clk_in(clk_in), .rst_in(rst_in),
        .latch_in(p0_eff_latch), .dir_in(p0_eff_dir), .pin_in(p0_pin_in),
        .pin_out(p0_pin_out), .pin_oe_n_out(p0_oe_n_out),
        .pullup_out(p0_pullup_out), .sync_out(p0_sync));
    rtop_pin_port u_p4 (.clk_in(clk_in), .rst_in(rst_in),
        .latch_in(p4_latch), .dir_in(p4_dir), .pin_in(p4_pin_in),
        .pin_out(p4_pin_out), .pin_oe_n_out(p4_oe_n_out),
        .pullup_out(p4_pullup_out), .sync_out(p4_sync));
    rtop_pin_port u_p5 (.clk_in(clk_in), .rst_in(rst_in),
        .latch_in(p5_latch), .dir_in(p5_dir), .pin_in(p5_pin_in),
        .pin_out(p5_pin_out), .pin_oe_n_out(p5_oe_n_out),
        .pullup_out(p5_pullup_out), .sync_out(p5_sync));
    rtop_pin_port u_p6 (.clk_in(clk_in), .rst_in(rst_in),
        .latch_in(p6_latch), .dir_in(p6_dir), .pin_in(p6_pin_in),
        .pin_out(p6_pin_out), .pin_oe_n_out(p6_oe_n_out),
        .pullup_out(p6_pullup_out), .sync_out(p6_sync));
    rtop_pin_port u_p9 (.clk_in(clk_in), .rst_in(rst_in),
        .latch_in(p9_latch), .dir_in(p9_dir), .pin_in(p9_pin_in),
        .pin_out(p9_pin_out), .pin_oe_n_out(p9_oe_n_out),
        .pullup_out(p9_pullup_out), .sync_out(p9_sync));

    // Register writes and timed copies into the output latches
    always @(posedge clk_in) begin
        if (rst_in) begin
            p0_latch <= `RTOP_RST_BYTE;
            p0_dir <= `RTOP_RST_DIR;
            p4_latch <= `RTOP_RST_BYTE;
            p4_dir <= `RTOP_RST_DIR;
            p5_latch <= `RTOP_RST_BYTE;
            p5_dir <= `RTOP_RST_DIR;
            p6_latch <= `RTOP_RST_BYTE;
            p6_dir <= `RTOP_RST_DIR;
            p8_latch <= `RTOP_RST_BYTE;
            p8_dir <= `RTOP_RST_DIR;
            p9_latch <= `RTOP_RST_BYTE;
            p9_dir <= `RTOP_RST_DIR;
            p0_buf <= `RTOP_RST_BYTE;
            p0_mode <= 4'h0;
            p8_buf <= 2'h0;
            port8_mode_ctrl <= 6'h00;
            head_switch_ctrl_reg <= 2'h0;
            pv_pat <= PV_PATTERN;
        end else begin
            if (wr_in) begin
                case (addr_in)
                    `RTOP_P0_DIR: p0_dir <= wdata_in;
                    `RTOP_P4_LATCH: p4_latch <= wdata_in;
                    `RTOP_P4_DIR: p4_dir <= wdata_in;
                    `RTOP_P5_LATCH: p5_latch <= wdata_in;
                    `RTOP_P5_DIR: p5_dir <= wdata_in;
                    `RTOP_P6_LATCH: p6_latch <= wdata_in;
                    `RTOP_P6_DIR: p6_dir <= wdata_in;
                    `RTOP_P8_LATCH: p8_latch <= wdata_in;
                    `RTOP_P8_DIR: p8_dir <= wdata_in;
                    `RTOP_P9_LATCH: p9_latch <= wdata_in;
                    `RTOP_P9_DIR: p9_dir <= wdata_in;
                    // RULE15: buffer waits for trigger
                    `RTOP_P0_BUF: p0_buf <= wdata_in;
                    `RTOP_P0_MODE: p0_mode <= wdata_in[3:0];
                    `RTOP_P8_BUF: p8_buf <= wdata_in[1:0];
                    `RTOP_P8_MODE: port8_mode_ctrl <= wdata_in[5:0];
                    `RTOP_HSW_CTRL: head_switch_ctrl_reg <= wdata_in[1:0];
                    // RULE16: pattern set by software
                    `RTOP_PV_PAT: pv_pat <= wdata_in;
                    default: ;
                endcase
            end
            // RULE15: unassigned nibble is plain
            if (wr_in && addr_in == `RTOP_P0_LATCH) begin
                if (!p0_mode[`RTOP_P0M_HI_EN])
                    p0_latch[7:4] <= wdata_in[7:4];
                if (!p0_mode[`RTOP_P0M_LO_EN])
                    p0_latch[3:0] <= wdata_in[3:0];
            end
            // RULE3: copy buffer on trigger
            if (p0_mode[`RTOP_P0M_HI_EN] && hi_trig)
                p0_latch[7:4] <= p0_buf[7:4];
            if (p0_mode[`RTOP_P0M_LO_EN] && lo_trig)
                p0_latch[3:0] <= p0_buf[3:0];
        end
    end

    // RULE10: head levels follow match a
    always @(posedge clk_in) begin
        if (rst_in) begin
            hsw_out <= 2'h0;
        end else if (wr_in && addr_in == `RTOP_HSW_CTRL) begin
            // RULE11: write shows at once
            hsw_out <= wdata_in[1:0];
        end else if (timer0_match_a_in) begin
            hsw_out <= head_switch_ctrl_reg;
        end
    end

    // RULE14: repeated pattern per trigger
    always @(posedge clk_in) begin
        if (rst_in) begin
            pv_out <= 2'h2;
            pv_run <= 1'b0;
            pv_idx <= 3'h0;
            pv_rep <= 4'h0;
            pv_cnt <= 16'h0000;
        end else if (b0_en && b0_trig) begin
            // RULE12: level or high impedance
            pv_out <= {p8_buf[`RTOP_P8B_HIZ], p8_buf[`RTOP_P8B_LVL]};
            pv_run <= port8_mode_ctrl[`RTOP_P8M_PVMODE];
            pv_idx <= 3'h0;
            pv_rep <= 4'h0;
            pv_cnt <= 16'h0000;
        end else if (pv_run) begin
            if (pv_cnt == PV_STEP_CYC - 16'h0001) begin
                pv_cnt <= 16'h0000;
                pv_idx <= pv_idx + 3'h1;
                if (pv_idx == 3'h7) begin
                    if (pv_rep == `RTOP_PV_REPEAT)
                        pv_run <= 1'b0;
                    pv_rep <= pv_rep + 4'h1;
                end
            end else begin
                pv_cnt <= pv_cnt + 16'h0001;
            end
        end
    end

    always @* begin
        pv_level = pv_run ? pv_pat[pv_idx] : pv_out[0];
        pv_hiz = pv_run ? 1'b0 : pv_out[1];
        // RULE13: superimposed horizontal sync
        if (port8_mode_ctrl[`RTOP_P8M_HSYNC] && !pv_hiz)
            pv_level = pv_level & ~hsync_in;
    end

    // RULE5: port-8 assignment, bit 0 alone and bits 2, 3 together
    always @(posedge clk_in) begin
        if (rst_in) begin
            p8_pin_out <= 8'h00;
            p8_oe_n_out <= 8'hff;
            p8_pullup_out <= 8'h00;
        end else begin
            p8_pin_out <= p8_latch & 8'hfd;
            p8_oe_n_out <= p8_dir | 8'h02;
            p8_pullup_out <= p8_dir & 8'hfd;
            if (b0_en) begin
                p8_pin_out[0] <= pv_level;
                p8_oe_n_out[0] <= pv_hiz;
                p8_pullup_out[0] <= 1'b0;
            end
            // RULE9: head levels on bits 2, 3
            if (hs_en) begin
                p8_pin_out[2] <= hsw_out[`RTOP_HSW_HEAD];
                p8_pin_out[3] <= hsw_out[`RTOP_HSW_CHROMA];
                p8_oe_n_out[3:2] <= 2'h0;
                p8_pullup_out[3:2] <= 2'h0;
            end
        end
    end

    // RULE2: input only, two-stage sync
    always @(posedge clk_in) begin
        if (rst_in) begin
            p7_meta <= 8'h00;
            p7_sync <= 8'h00;
            p8_meta <= 8'h00;
            p8_sync <= 8'h00;
        end else begin
            p7_meta <= p7_pin_in;
            p7_sync <= p7_meta;
            p8_meta <= p8_pin_in;
            p8_sync <= p8_meta;
        end
    end

    always @(posedge clk_in) begin
        if (rst_in) begin
            rdata_out <= 8'h00;
        end else if (rd_in) begin
            case (addr_in)
                `RTOP_P0_LATCH: rdata_out <= p0_latch;
                `RTOP_P0_DIR: rdata_out <= p0_dir;
                `RTOP_P4_LATCH: rdata_out <= p4_latch;
                `RTOP_P4_DIR: rdata_out <= p4_dir;
                `RTOP_P5_LATCH: rdata_out <= p5_latch;
                `RTOP_P5_DIR: rdata_out <= p5_dir;
                `RTOP_P6_LATCH: rdata_out <= p6_latch;
                `RTOP_P6_DIR: rdata_out <= p6_dir;
                `RTOP_P7_PINS: rdata_out <= p7_sync;
                `RTOP_P8_LATCH: rdata_out <= p8_latch & 8'hfd;
                `RTOP_P8_DIR: rdata_out <= p8_dir & 8'hfd;
                `RTOP_P9_LATCH: rdata_out <= p9_latch;
                `RTOP_P9_DIR: rdata_out <= p9_dir;
                `RTOP_P0_BUF: rdata_out <= p0_buf;
                `RTOP_P0_MODE: rdata_out <= {4'h0, p0_mode};
                `RTOP_P8_BUF: rdata_out <= {6'h00, p8_buf};
                `RTOP_P8_MODE: rdata_out <= {2'h0, port8_mode_ctrl};
                `RTOP_HSW_CTRL: rdata_out <= {6'h00, head_switch_ctrl_reg};
                `RTOP_PV_PAT: rdata_out <= pv_pat;
                `RTOP_P0_IN: rdata_out <= p0_sync;
                `RTOP_P4_IN: rdata_out <= p4_sync;
                `RTOP_P5_IN: rdata_out <= p5_sync;
                `RTOP_P6_IN: rdata_out <= p6_sync;
                `RTOP_P8_IN: rdata_out <= p8_sync & 8'hfd;
                `RTOP_P9_IN: rdata_out <= p9_sync;
                default: rdata_out <= 8'h00;
            endcase
        end else begin
            rdata_out <= 8'h00;
        end
    end
endmodule

// ---- testbench/rtop_timed_port_assertions.sv ----
// Purpose: Port checks for the timed output port.
// Assumes: One clock, synchronous active-high reset.
// Notes: Bound to the top module below.
`timescale 1ns/1ns
`include "rtop_regs.vh"
module rtop_timed_port_assertions (
    input wire clk_in,
    input wire rst_in,
    input wire [4:0] addr_in,
    input wire [7:0] wdata_in,
    input wire wr_in,
    input wire timer0_match_b_in,
    input wire timer0_match_c_in,
    input wire alt_trigger_in,
    input wire [7:0] p0_pin_out,
    input wire [7:0] p0_oe_n_out,
    input wire [7:0] p4_pin_out,
    input wire [7:0] p4_oe_n_out,
    input wire [7:0] p4_pullup_out,
    input wire [7:0] p8_pin_out,
    input wire [7:0] p8_oe_n_out,
    input wire [7:0] p8_pullup_out,
    input wire [7:0] p9_oe_n_out,
    input wire [7:0] p9_pullup_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    a_p4_pullup_dir: assert property (!$past(rst_in) |->
        p4_pullup_out == p4_oe_n_out) else $error("p4 pull-up off");
    a_p9_pullup_dir: assert property (!$past(rst_in) |->
        p9_pullup_out == p9_oe_n_out) else $error("p9 pull-up off");
    a_p8_bit_absent: assert property (p8_oe_n_out[1] &&
        !p8_pin_out[1] && !p8_pullup_out[1]) else $error("p8 bit1 used");
    a_p4_dir_write: assert property (wr_in &&
        addr_in == `RTOP_P4_DIR |-> ##2 p4_oe_n_out == $past(wdata_in, 2))
        else $error("p4 direction not applied");
    a_p4_latch_write: assert property (wr_in &&
        addr_in == `RTOP_P4_LATCH |-> ##2 p4_pin_out == $past(wdata_in, 2))
        else $error("p4 latch not applied");
    a_p0_pin_cause: assert property ($changed(p0_pin_out) |->
        $past(wr_in, 2) || $past(timer0_match_b_in, 2) ||
        $past(timer0_match_c_in, 2) || $past(alt_trigger_in, 2))
        else $error("p0 pins moved without cause");
    a_p4_pin_cause: assert property ($changed(p4_pin_out) |->
        $past(wr_in, 2)) else $error("p4 pins moved without write");
    a_reset_hiz: assert property ($past(rst_in) |->
        p0_oe_n_out == 8'hff && p8_oe_n_out == 8'hff)
        else $error("pins driven after reset");
    cover property (timer0_match_b_in);
    cover property (wr_in && addr_in == `RTOP_P0_BUF);
    cover property ($changed(p8_pin_out));
endmodule
bind rtop_timed_port rtop_timed_port_assertions u_chk (.clk_in(clk_in),
    .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
    .timer0_match_b_in(timer0_match_b_in),
    .timer0_match_c_in(timer0_match_c_in), .alt_trigger_in(alt_trigger_in),
    .p0_pin_out(p0_pin_out), .p0_oe_n_out(p0_oe_n_out),
    .p4_pin_out(p4_pin_out), .p4_oe_n_out(p4_oe_n_out),
    .p4_pullup_out(p4_pullup_out), .p8_pin_out(p8_pin_out),
    .p8_oe_n_out(p8_oe_n_out), .p8_pullup_out(p8_pullup_out),
    .p9_oe_n_out(p9_oe_n_out), .p9_pullup_out(p9_pullup_out));

// ---- testbench/rtop_video_partner.sv ----
// Purpose: Pin-side circuitry seen by one 8-bit port.
// Assumes: Pull-up where enabled, external drive optional.
// Notes: A floating bit flips every cycle.
`timescale 1ns/1ns
module rtop_video_partner (
    input wire clk_in,
    input wire [7:0] pin_out_in,
    input wire [7:0] oe_n_in,
    input wire [7:0] pullup_in,
    input wire [7:0] ext_en_in,
    input wire [7:0] ext_val_in,
    output reg [7:0] pin_in_out
);
    reg [7:0] last = 8'h00;
    integer i;
    always @* begin
        for (i = 0; i < 8; i = i + 1) begin
            if (!oe_n_in[i])
                pin_in_out[i] = pin_out_in[i];
            else if (ext_en_in[i])
                pin_in_out[i] = ext_val_in[i];
            else if (pullup_in[i])
                pin_in_out[i] = 1'b1;
            else
                pin_in_out[i] = ~last[i];
        end
    end
    always @(posedge clk_in) begin
        last <= pin_in_out;
    end
endmodule

// ---- testbench/rtop_timed_port_bench.sv ----
// Purpose: Self-checking bench for the timed output port.
// Assumes: Pseudo vsync step shortened to 4 cycles.
// Notes: Triggers are one-cycle pulses from the bench.
`timescale 1ns/1ns
`include "rtop_regs.vh"
module rtop_timed_port_bench;
    reg clk_in = 1'b0;
    reg rst_in = 1'b1;
    reg [4:0] addr_in = 5'h00;
    reg [7:0] wdata_in = 8'h00;
    reg wr_in = 1'b0;
    reg rd_in = 1'b0;
    reg [5:0] trig = 6'h00;
    reg hsync_in = 1'b0;
    reg [7:0] p7_in = 8'h00;
    reg [7:0] ext_en = 8'h00;
    reg [7:0] ext_val = 8'h00;
    reg [47:0] tab [0:3];
    wire [7:0] rdata_out, p0_o, p0_oe, p0_pu, p0_i, p4_o, p4_oe, p4_pu;
    wire [7:0] p4_i, p8_o, p8_oe, p8_pu, p8_i;
    wire [7:0] p5_o, p5_oe, p5_pu, p6_o, p6_oe, p6_pu, p9_o;
    integer err_count = 0;
    integer check_count = 0;
    integer cycles = 0;
    integer k;
    rtop_timed_port #(.PV_STEP_CYC(16'd4)) dut (.clk_in(clk_in),
        .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .timer0_match_a_in(trig[0]), .timer0_match_b_in(trig[1]),
        .timer0_match_c_in(trig[2]), .timer1_match_d_in(trig[3]),
        .timer5_match_in(trig[4]), .alt_trigger_in(trig[5]),
        .hsync_in(hsync_in), .p0_pin_in(p0_i), .p0_pin_out(p0_o),
        .p0_oe_n_out(p0_oe), .p0_pullup_out(p0_pu), .p4_pin_in(p4_i),
        .p4_pin_out(p4_o), .p4_oe_n_out(p4_oe), .p4_pullup_out(p4_pu),
        .p5_pin_in(8'h00), .p5_pin_out(p5_o), .p5_oe_n_out(p5_oe),
        .p5_pullup_out(p5_pu), .p6_pin_in(8'h00), .p6_pin_out(p6_o),
        .p6_oe_n_out(p6_oe), .p6_pullup_out(p6_pu), .p7_pin_in(p7_in),
        .p8_pin_in(p8_i), .p8_pin_out(p8_o), .p8_oe_n_out(p8_oe),
        .p8_pullup_out(p8_pu), .p9_pin_in(8'h00), .p9_pin_out(p9_o),
        .p9_oe_n_out(), .p9_pullup_out());
    rtop_video_partner u_p0 (.clk_in(clk_in), .pin_out_in(p0_o),
        .oe_n_in(p0_oe), .pullup_in(p0_pu), .ext_en_in(ext_en),
        .ext_val_in(ext_val), .pin_in_out(p0_i));
    rtop_video_partner u_p4 (.clk_in(clk_in), .pin_out_in(p4_o),
        .oe_n_in(p4_oe), .pullup_in(p4_pu), .ext_en_in(ext_en),
        .ext_val_in(ext_val), .pin_in_out(p4_i));
    rtop_video_partner u_p8 (.clk_in(clk_in), .pin_out_in(p8_o),
        .oe_n_in(p8_oe), .pullup_in(p8_pu), .ext_en_in(ext_en),
        .ext_val_in(ext_val), .pin_in_out(p8_i));
    initial begin
        forever #50 clk_in = ~clk_in;
    end
    task chk(input string n, input [7:0] e, input [7:0] g);
        begin
            check_count = check_count + 1;
            if (g !== e) begin
                err_count = err_count + 1;
                $display("CHECK FAILED %s expected %h seen %h", n, e, g);
            end
        end
    endtask
    // Ends with pins settled two edges after the write
    task wr(input [4:0] a, input [7:0] d);
        begin
            @(posedge clk_in);
            addr_in <= a;
            wdata_in <= d;
            wr_in <= 1'b1;
            @(posedge clk_in);
            wr_in <= 1'b0;
            repeat (2) @(negedge clk_in);
        end
    endtask
    task rchk(input [4:0] a, input [7:0] e, input string n);
        begin
            @(posedge clk_in);
            addr_in <= a;
            rd_in <= 1'b1;
            @(posedge clk_in);
            rd_in <= 1'b0;
            @(negedge clk_in);
            chk(n, e, rdata_out);
        end
    endtask
    task pulse(input [5:0] t);
        begin
            @(posedge clk_in);
            trig <= t;
            @(posedge clk_in);
            trig <= 6'h00;
            repeat (3) @(negedge clk_in);
        end
    endtask
    task print_verdict;
        begin
            $display("mismatches %0d checks %0d", err_count, check_count);
            if (err_count == 0 && check_count > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    always @(posedge clk_in) begin
        cycles = cycles + 1;
        if (cycles == 5000) begin
            err_count = err_count + 1;
            print_verdict;
        end
    end
    initial begin
        // Mode, buffer, wrong and right trigger, pins before and after
        tab[0] = 48'h02_a5_04_02_00_a0;
        tab[1] = 48'h01_3c_02_04_a0_ac;
        tab[2] = 48'h07_96_02_04_ac_96;
        tab[3] = 48'h0f_69_04_20_96_69;
        repeat (12) @(posedge clk_in);
        rst_in <= 1'b0;
        rchk(`RTOP_P0_DIR, `RTOP_RST_DIR, "p0 dir");
        rchk(`RTOP_PV_PAT, `RTOP_RST_PAT, "pv pattern");
        rchk(5'h1f, 8'h00, "unmapped");
        rchk(`RTOP_P4_IN, 8'hff, "p4 pulled up");
        wr(`RTOP_P4_LATCH, 8'ha5);
        wr(`RTOP_P4_DIR, 8'h0f);
        chk("p4 pullup", 8'h0f, p4_pu);
        @(posedge clk_in);
        ext_en <= 8'h0f;
        ext_val <= 8'h03;
        p7_in <= 8'h3c;
        repeat (4) @(posedge clk_in);
        rchk(`RTOP_P4_IN, 8'ha3, "p4 mixed");
        rchk(`RTOP_P7_PINS, 8'h3c, "p7 pins");
        wr(`RTOP_P5_LATCH, 8'h3c);
        wr(`RTOP_P5_DIR, 8'h0f);
        wr(`RTOP_P6_LATCH, 8'hc3);
        wr(`RTOP_P6_DIR, 8'hf0);
        wr(`RTOP_P9_LATCH, 8'h5a);
        chk("p5 pins", 8'h3c, p5_o);
        chk("p5 drive", 8'h0f, p5_oe);
        chk("p5 pullup", 8'h0f, p5_pu);
        chk("p6 pins", 8'hc3, p6_o);
        chk("p6 drive", 8'hf0, p6_oe);
        chk("p6 pullup", 8'hf0, p6_pu);
        chk("p9 pins", 8'h5a, p9_o);
        wr(`RTOP_P0_DIR, 8'h00);
        chk("p0 pullup", 8'h00, p0_pu);
        for (k = 0; k < 4; k = k + 1) begin
            wr(`RTOP_P0_MODE, tab[k][47:40]);
            wr(`RTOP_P0_BUF, tab[k][39:32]);
            chk("p0 buffered", tab[k][15:8], p0_o);
            pulse(tab[k][29:24]);
            chk("p0 wrong trig", tab[k][15:8], p0_o);
            pulse(tab[k][21:16]);
            chk("p0 trig", tab[k][7:0], p0_o);
        end
        wr(`RTOP_P0_MODE, 8'h01);
        wr(`RTOP_P0_LATCH, 8'hf0);
        chk("p0 plain nibble", 8'hf9, p0_o);
        chk("p8 pullup", 8'hfd, p8_pu);
        wr(`RTOP_P8_DIR, 8'h00);
        for (k = 0; k < 4; k = k + 1) begin
            wr(`RTOP_P8_MODE, {4'h0, k[1:0], 2'b01});
            wr(`RTOP_P8_BUF, {7'h00, ~k[0]});
            pulse(6'h3e & ~(6'h02 << k));
            chk("p8 wrong trig", {7'h00, k[0]}, {7'h00, p8_o[0]});
            pulse(6'h02 << k);
            chk("p8 trig", {7'h00, ~k[0]}, {7'h00, p8_o[0]});
        end
        chk("p8 drive", 8'h00, {7'h00, p8_oe[0]});
        wr(`RTOP_P8_BUF, 8'h02);
        pulse(6'h10);
        chk("p8 hiz", 8'h01, {7'h00, p8_oe[0]});
        wr(`RTOP_P8_MODE, 8'h1d);
        wr(`RTOP_P8_BUF, 8'h01);
        pulse(6'h10);
        @(posedge clk_in);
        hsync_in <= 1'b1;
        repeat (3) @(negedge clk_in);
        chk("hsync low", 8'h00, {7'h00, p8_o[0]});
        @(posedge clk_in);
        hsync_in <= 1'b0;
        repeat (3) @(negedge clk_in);
        chk("hsync gone", 8'h01, {7'h00, p8_o[0]});
        wr(`RTOP_P8_MODE, 8'h02);
        wr(`RTOP_HSW_CTRL, 8'h03);
        chk("head pins", 8'h0c, p8_o & 8'h0c);
        chk("head drive", 8'h00, p8_oe & 8'h0c);
        pulse(6'h01);
        chk("head on match", 8'h0c, p8_o & 8'h0c);
        wr(`RTOP_HSW_CTRL, 8'h01);
        chk("head rewrite", 8'h04, p8_o & 8'h0c);
        wr(`RTOP_PV_PAT, 8'hc5);
        wr(`RTOP_P8_MODE, 8'h21);
        wr(`RTOP_P8_BUF, 8'h00);
        pulse(6'h02);
        for (k = 0; k < 32; k = k + 1) begin
            repeat (k ? 4 : 2) @(negedge clk_in);
            chk("pv bit", (8'hc5 >> k[2:0]) & 8'h01, {7'h00, p8_o[0]});
        end
        repeat (4) @(negedge clk_in);
        chk("pv hold", 8'h00, {7'h00, p8_o[0]});
        print_verdict;
    end
endmodule
